// File: hw/pin_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_clock
// Notes: First stage feeds only the second
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_pins
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stable_ff;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_ff <= '0;
			stable_ff <= '0;
		end else begin
			meta_ff <= i_pins;
			stable_ff <= meta_ff;
		end
	end

	assign o_pins = stable_ff;
endmodule

// File: hw/pod_adapter_pkg.sv
// Purpose: Shared constants and types for the pod RAM run and target bus adapter
// Assumes: 50 MHz single clock, asynchronous active-low reset
// Notes: Addresses are the troubleshooter's own address space
package pod_adapter_pkg;

	// ************************************************
	// Clock and timing
	// ************************************************
	localparam int CLOCK_NS = 20;
	localparam int EXT_CYCLE_NS = 1875;
	localparam int AS_START_NS = 40;
	localparam int AS_END_NS = 400;
	localparam int ADDR_END_NS = 600;
	localparam int DS_START_NS = 800;
	localparam int DS_END_NS = 1700;
	localparam int HOST_RESET_NS = 1000;
	// Longest cycle rounds down, phase edges round up
	localparam int EXT_CYCLES = EXT_CYCLE_NS / CLOCK_NS;
	localparam int AS_START = (AS_START_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int AS_END = (AS_END_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int ADDR_END = (ADDR_END_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int DS_START = (DS_START_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int DS_END = (DS_END_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int HOST_RESET_CYCLES = (HOST_RESET_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int CNT_W = 7;

	// ************************************************
	// Address map
	// ************************************************
	localparam logic [15:0] ADDR_P1 = 16'h2000;
	localparam logic [15:0] ADDR_P2 = 16'h2001;
	localparam logic [15:0] ADDR_MODE = 16'h2002;
	localparam logic [15:0] ADDR_P0L = 16'h2004;
	localparam logic [15:0] ADDR_P0H = 16'h2005;
	localparam logic [15:0] ADDR_P3L = 16'h2006;
	localparam logic [15:0] ADDR_P3H = 16'h2007;
	localparam logic [3:0] PMEM_TOP = 4'h0;
	localparam logic [7:0] DMEM_PAGE = 8'h11;
	localparam logic [7:0] RAM_PAGE = 8'h30;
	localparam int RAM_DEPTH = 256;

	// ************************************************
	// Mode register and reset values
	// ************************************************
	localparam int MODE_DM_BIT = 0;
	localparam int MODE_READBACK_BIT = 4;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] P2_RESET = 8'hff;
	localparam logic [7:0] PORT_RESET = 8'h00;

	// ************************************************
	// Host port numbers
	// ************************************************
	localparam logic [2:0] HPORT_P1 = 3'h1;
	localparam logic [2:0] HPORT_P2 = 3'h2;
	localparam logic [2:0] HPORT_X4 = 3'h4;
	localparam logic [2:0] HPORT_X5 = 3'h5;
	localparam logic [2:0] HPORT_X6 = 3'h6;
	localparam logic [2:0] HPORT_X7 = 3'h7;

	typedef enum logic [3:0] {
		TGT_NONE, TGT_PMEM, TGT_DMEM, TGT_P1, TGT_P2, TGT_MODE,
		TGT_P0L, TGT_P0H, TGT_P3L, TGT_P3H, TGT_RAM
	} target_t;

	typedef enum logic [1:0] {ST_IDLE, ST_RAM, ST_EXT, ST_RESET} state_t;

endpackage

// File: hw/pod_ram.sv
// Purpose: Executable pod RAM, one byte per address
// Assumes: Synchronous write and registered read
// Notes: Contents are undefined after power-up
module pod_ram #(
	parameter int DEPTH = 256
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_we,
	input wire logic [$clog2(DEPTH)-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [DEPTH];
	logic [7:0] rdata_ff;

	// Array carries no reset so it maps onto block memory
	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= mem[i_addr];
		end
	end

	assign o_rdata = rdata_ff;
endmodule

// File: hw/pod_ram_run_and_target_bus_adapter.sv
// Purpose: Emulated target bus and ports driven from troubleshooter or run-mode host
// Assumes: Requests come from same-clock logic; target pins are asynchronous
// Notes: Run mode is a level; each edge of it resets the host
//
// Summary of operation
// - A 256-byte pod RAM is written and read back at troubleshooter addresses 3000-30FF.
// - In run mode the host's fetches at 0000-00FF are served from the pod RAM.
// - Pod programs are host machine code; the adapter never executes target instructions.
// - In run mode emulated port 1 carries fetches and must not serve as a static port.
// - Run start resets the host and returns every emulated port to input mode.
// - Run end resets the host again; ports and mode must then be set up anew.
// - Expander ports 4 and 5 map to port 0 nibbles, ports 6 and 7 to port 3 nibbles.
// - Host port 1 maps to emulated port 2, host port 2 to the mode register, serial to test input.
// - An external memory cycle lasts one target cycle, 1.875 us per cycle.
// - Data-space and write selects are asserted only inside the transfer strobe pulse.
// - Program fetches leave data-space and write selects deasserted.
// - Probe sync pulses mark both the address phase and the data phase.
// - External cycles multiplex port 1 with strobes on own pins; port 0 keeps its static data, no high address is driven.
// - Data-space select goes low when enabled and write select only for writes.
module pod_ram_run_and_target_bus_adapter
	import pod_adapter_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_run_pod_program,
	input wire logic i_ts_valid,
	input wire logic i_ts_write,
	input wire logic [15:0] i_ts_addr,
	input wire logic [7:0] i_ts_wdata,
	output logic o_ts_ready,
	output logic o_ts_done,
	input wire logic i_host_valid,
	input wire logic i_host_fetch,
	input wire logic i_host_write,
	input wire logic [7:0] i_host_addr,
	input wire logic [2:0] i_host_port,
	input wire logic [7:0] i_host_wdata,
	output logic o_host_ready,
	output logic o_host_done,
	output logic o_host_reset_n,
	output logic o_host_test_input,
	output logic [7:0] o_rdata,
	input wire logic [7:0] i_port0,
	output logic [7:0] o_port0,
	output logic [7:0] o_port0_oe,
	input wire logic [7:0] i_port1,
	output logic [7:0] o_port1,
	output logic o_port1_oe,
	input wire logic [7:0] i_port2,
	output logic [7:0] o_port2,
	output logic [7:0] o_port2_oe,
	input wire logic [3:0] i_port3_low,
	input wire logic [3:0] i_port3_high,
	output logic [3:0] o_port3_high,
	output logic o_port3_high_oe,
	input wire logic i_serial_in_line,
	output logic o_address_strobe_n,
	output logic o_transfer_strobe_n,
	output logic o_data_space_select_n,
	output logic o_write_select_n,
	output logic o_probe_sync
);
	// ************************************************
	// Decoding
	// ************************************************
	function automatic target_t decode_target(input logic [15:0] addr);
		target_t t;
		t = TGT_NONE;
		if (addr[15:12] == PMEM_TOP) t = TGT_PMEM;
		else if (addr[15:8] == DMEM_PAGE) t = TGT_DMEM;
		else if (addr[15:8] == RAM_PAGE) t = TGT_RAM;
		else if (addr == ADDR_P1) t = TGT_P1;
		else if (addr == ADDR_P2) t = TGT_P2;
		else if (addr == ADDR_MODE) t = TGT_MODE;
		else if (addr == ADDR_P0L) t = TGT_P0L;
		else if (addr == ADDR_P0H) t = TGT_P0H;
		else if (addr == ADDR_P3L) t = TGT_P3L;
		else if (addr == ADDR_P3H) t = TGT_P3H;
		return t;
	endfunction

	// Host I/O instructions land on the same targets as troubleshooter addresses
	function automatic logic [15:0] host_port_addr(input logic [2:0] port);
		logic [15:0] a;
		a = 16'hffff;
		case (port)
			HPORT_P1: a = ADDR_P2;
			HPORT_P2: a = ADDR_MODE;
			HPORT_X4: a = ADDR_P0L;
			HPORT_X5: a = ADDR_P0H;
			HPORT_X6: a = ADDR_P3L;
			HPORT_X7: a = ADDR_P3H;
			default: a = 16'hffff;
		endcase
		return a;
	endfunction

	// ************************************************
	// Pin synchronisers
	// ************************************************
	logic [32:0] pins_raw;
	logic [32:0] pins_s;
	logic [7:0] p0_s;
	logic [7:0] p1_s;
	logic [7:0] p2_s;
	logic [3:0] p3l_s;
	logic [3:0] p3h_s;
	logic serial_s;

	assign pins_raw = {i_serial_in_line, i_port3_high, i_port3_low, i_port2, i_port1, i_port0};
	pin_sync #(.WIDTH(33)) u_sync (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_pins(pins_raw),
		.o_pins(pins_s)
	);
	assign {serial_s, p3h_s, p3l_s, p2_s, p1_s, p0_s} = pins_s;
	assign o_host_test_input = serial_s;

	// ************************************************
	// State
	// ************************************************
	state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic run_ff, nxt_run;
	logic from_host_ff, nxt_from_host;
	logic done_ff, nxt_done;
	logic [7:0] rdata_ff, nxt_rdata;
	logic ext_data_ff, nxt_ext_data;
	logic ext_wr_ff, nxt_ext_wr;
	logic [7:0] ext_addr_ff, nxt_ext_addr;
	logic [7:0] ext_wdata_ff, nxt_ext_wdata;
	logic [7:0] mode_ff, nxt_mode;
	logic [7:0] p0_out_ff, nxt_p0_out;
	logic [1:0] p0_oe_ff, nxt_p0_oe;
	logic [7:0] p1_out_ff, nxt_p1_out;
	logic p1_oe_ff, nxt_p1_oe;
	logic [7:0] p2_out_ff, nxt_p2_out;
	logic [3:0] p3h_out_ff, nxt_p3h_out;
	logic p3h_oe_ff, nxt_p3h_oe;

	logic req_valid, req_write, accept, readback;
	logic [15:0] req_addr;
	logic [7:0] req_wdata, ram_q;
	target_t tgt;
	logic in_ext, as_win, ds_win, addr_win, dat_win;

	// run mode serves only host requests, bus carries fetches
	assign req_valid = run_ff ? i_host_valid : i_ts_valid;
	assign req_write = run_ff ? (i_host_write & ~i_host_fetch) : i_ts_write;
	// host fetch relocated into pod RAM, host code runs as is
	assign req_addr = !run_ff ? i_ts_addr :
		(i_host_fetch ? {RAM_PAGE, i_host_addr} : host_port_addr(i_host_port));
	assign req_wdata = run_ff ? i_host_wdata : i_ts_wdata;
	assign tgt = decode_target(req_addr);
	assign o_ts_ready = (state_ff == ST_IDLE) && !run_ff && (i_run_pod_program == run_ff);
	assign o_host_ready = (state_ff == ST_IDLE) && run_ff && (i_run_pod_program == run_ff);
	assign accept = req_valid && (run_ff ? o_host_ready : o_ts_ready);
	assign readback = mode_ff[MODE_READBACK_BIT];

	// pod RAM loaded and read back
	pod_ram #(.DEPTH(RAM_DEPTH)) u_ram (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_we(accept && (tgt == TGT_RAM) && req_write),
		.i_addr(req_addr[7:0]),
		.i_wdata(req_wdata),
		.o_rdata(ram_q)
	);

	// ************************************************
	// Control next state
	// ************************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_from_host = from_host_ff;
		nxt_done = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_ext_data = ext_data_ff;
		nxt_ext_wr = ext_wr_ff;
		nxt_ext_addr = ext_addr_ff;
		nxt_ext_wdata = ext_wdata_ff;
		nxt_mode = mode_ff;
		nxt_p0_out = p0_out_ff;
		nxt_p0_oe = p0_oe_ff;
		nxt_p1_out = p1_out_ff;
		nxt_p1_oe = p1_oe_ff;
		nxt_p2_out = p2_out_ff;
		nxt_p3h_out = p3h_out_ff;
		nxt_p3h_oe = p3h_oe_ff;
		case (state_ff)
			ST_IDLE: begin
				if (i_run_pod_program != run_ff) begin
					// host reset on both edges, ports back to input
					nxt_run = i_run_pod_program;
					nxt_state = ST_RESET;
					nxt_cnt = '0;
					nxt_mode = MODE_RESET;
					nxt_p0_oe = 2'b00;
					nxt_p1_oe = 1'b0;
					nxt_p2_out = P2_RESET;
					nxt_p3h_oe = 1'b0;
				end else if (accept) begin
					nxt_from_host = run_ff;
					nxt_done = 1'b1;
					case (tgt)
						TGT_RAM: begin
							nxt_done = 1'b0;
							nxt_state = ST_RAM;
						end
						TGT_PMEM, TGT_DMEM: begin
							// low address on bus, page not driven, port 0 keeps its static data
							nxt_done = 1'b0;
							nxt_state = ST_EXT;
							nxt_cnt = '0;
							nxt_ext_data = (tgt == TGT_DMEM);
							nxt_ext_wr = (tgt == TGT_DMEM) && req_write;
							nxt_ext_addr = req_addr[7:0];
							nxt_ext_wdata = req_wdata;
						end
						TGT_P1: begin
							if (req_write) begin
								nxt_p1_out = req_wdata;
								nxt_p1_oe = 1'b1;
							end else begin
								nxt_rdata = p1_s;
							end
						end
						// host port 1 is emulated port 2, open-drain style
						TGT_P2: begin
							if (req_write) nxt_p2_out = req_wdata;
							else nxt_rdata = p2_s;
						end
						TGT_MODE: begin
							if (req_write) nxt_mode = req_wdata;
							else nxt_rdata = mode_ff;
						end
						// expander ports onto port 0 and port 3 nibbles
						TGT_P0L: begin
							if (req_write) begin
								nxt_p0_out[3:0] = req_wdata[3:0];
								nxt_p0_oe[0] = 1'b1;
							end else begin
								nxt_rdata = {4'h0, p0_s[3:0]};
								if (!readback) nxt_p0_oe[0] = 1'b0;
							end
						end
						TGT_P0H: begin
							if (req_write) begin
								nxt_p0_out[7:4] = req_wdata[3:0];
								nxt_p0_oe[1] = 1'b1;
							end else begin
								nxt_rdata = {4'h0, p0_s[7:4]};
								if (!readback) nxt_p0_oe[1] = 1'b0;
							end
						end
						TGT_P3L: begin
							if (!req_write) nxt_rdata = {4'h0, p3l_s};
						end
						TGT_P3H: begin
							if (req_write) begin
								nxt_p3h_out = req_wdata[3:0];
								nxt_p3h_oe = 1'b1;
							end else begin
								nxt_rdata = {4'h0, readback ? p3h_s : p3h_out_ff};
							end
						end
						default: nxt_rdata = 8'hff;
					endcase
				end
			end
			ST_RAM: begin
				nxt_rdata = ram_q;
				nxt_done = 1'b1;
				nxt_state = ST_IDLE;
			end
			ST_EXT: begin
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == CNT_W'(DS_END - 1) && !ext_wr_ff) nxt_rdata = p1_s;
				if (cnt_ff == CNT_W'(EXT_CYCLES - 1)) begin
					nxt_state = ST_IDLE;
					nxt_done = 1'b1;
					// External access clears any static port 1 data
					nxt_p1_oe = 1'b0;
					nxt_p1_out = PORT_RESET;
				end
			end
			ST_RESET: begin
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == CNT_W'(HOST_RESET_CYCLES - 1)) nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
			run_ff <= 1'b0;
			from_host_ff <= 1'b0;
			done_ff <= 1'b0;
			rdata_ff <= 8'h00;
			ext_data_ff <= 1'b0;
			ext_wr_ff <= 1'b0;
			ext_addr_ff <= 8'h00;
			ext_wdata_ff <= 8'h00;
			mode_ff <= MODE_RESET;
			p0_out_ff <= PORT_RESET;
			p0_oe_ff <= 2'b00;
			p1_out_ff <= PORT_RESET;
			p1_oe_ff <= 1'b0;
			p2_out_ff <= P2_RESET;
			p3h_out_ff <= 4'h0;
			p3h_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			from_host_ff <= nxt_from_host;
			done_ff <= nxt_done;
			rdata_ff <= nxt_rdata;
			ext_data_ff <= nxt_ext_data;
			ext_wr_ff <= nxt_ext_wr;
			ext_addr_ff <= nxt_ext_addr;
			ext_wdata_ff <= nxt_ext_wdata;
			mode_ff <= nxt_mode;
			p0_out_ff <= nxt_p0_out;
			p0_oe_ff <= nxt_p0_oe;
			p1_out_ff <= nxt_p1_out;
			p1_oe_ff <= nxt_p1_oe;
			p2_out_ff <= nxt_p2_out;
			p3h_out_ff <= nxt_p3h_out;
			p3h_oe_ff <= nxt_p3h_oe;
		end
	end

	// ************************************************
	// Pin outputs
	// ************************************************
	assign in_ext = (state_ff == ST_EXT);
	assign as_win = in_ext && cnt_ff >= CNT_W'(AS_START) && cnt_ff < CNT_W'(AS_END);
	assign ds_win = in_ext && cnt_ff >= CNT_W'(DS_START) && cnt_ff < CNT_W'(DS_END);
	assign addr_win = in_ext && cnt_ff < CNT_W'(ADDR_END);
	assign dat_win = ds_win && ext_wr_ff;
	// strobes rest high outside external cycles
	assign o_address_strobe_n = ~as_win;
	assign o_transfer_strobe_n = ~ds_win;
	// selects only in strobe of data cycles
	assign o_data_space_select_n = ~(ds_win && ext_data_ff && mode_ff[MODE_DM_BIT]);
	assign o_write_select_n = ~(ds_win && ext_wr_ff);
	// pulse at close of each phase
	assign o_probe_sync = in_ext && (cnt_ff == CNT_W'(AS_END) || cnt_ff == CNT_W'(DS_END));
	assign o_port1 = addr_win ? ext_addr_ff : (dat_win ? ext_wdata_ff : p1_out_ff);
	assign o_port1_oe = addr_win || dat_win || (!in_ext && p1_oe_ff);
	assign o_port0 = p0_out_ff;
	assign o_port0_oe = {{4{p0_oe_ff[1]}}, {4{p0_oe_ff[0]}}};
	// Port 2 only pulls low; written ones leave the line as input
	assign o_port2 = p2_out_ff;
	assign o_port2_oe = ~p2_out_ff;
	assign o_port3_high = p3h_out_ff;
	assign o_port3_high_oe = p3h_oe_ff;
	assign o_host_reset_n = (state_ff != ST_RESET);
	assign o_rdata = rdata_ff;
	assign o_ts_done = done_ff && !from_host_ff;
	assign o_host_done = done_ff && from_host_ff;

	// ************************************************
	// Assertions
	// ************************************************
	localparam int ext_len_c = EXT_CYCLES;
	localparam int ds_len_c = DS_END - DS_START;

	sequence ext_start_s;
		state_ff == ST_IDLE && nxt_state == ST_EXT;
	endsequence
	sequence ram_start_s;
		accept && tgt == TGT_RAM && !req_write;
	endsequence

	ext_cycle_len_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		ext_start_s |=> in_ext ##(ext_len_c - 1) in_ext ##1 (!in_ext && done_ff))
		else $error("external cycle length wrong");
	ds_width_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		$fell(o_transfer_strobe_n) |-> !o_transfer_strobe_n [*8] ##(ds_len_c - 7) o_transfer_strobe_n)
		else $error("transfer strobe width wrong");
	dm_in_ds_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!o_data_space_select_n |-> !o_transfer_strobe_n && o_address_strobe_n)
		else $error("data-space select outside strobe");
	write_in_ds_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!o_write_select_n |-> !o_transfer_strobe_n && ext_wr_ff)
		else $error("write select outside write strobe");
	fetch_no_select_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		in_ext && !ext_data_ff |-> o_data_space_select_n && o_write_select_n)
		else $error("select asserted in fetch");
	strobes_idle_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!in_ext |-> o_address_strobe_n && o_transfer_strobe_n)
		else $error("strobe active outside cycle");
	probe_phases_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		($rose(o_address_strobe_n) || $rose(o_transfer_strobe_n)) |-> o_probe_sync)
		else $error("probe pulse missing");
	ram_fetch_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		ram_start_s ##0 run_ff |=> !o_host_done ##1 (o_host_done && o_rdata == $past(ram_q)))
		else $error("pod RAM fetch answer wrong");
	host_reset_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		state_ff == ST_IDLE && i_run_pod_program != run_ff |=> !o_host_reset_n [*8])
		else $error("host reset missing on run edge");
	ports_input_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!o_host_reset_n |-> o_port0_oe == 8'h00 && !o_port1_oe && o_port2_oe == 8'h00
			&& !o_port3_high_oe)
		else $error("port driving during host reset");
endmodule

// File: testbench/pod_ram_run_and_target_bus_adapter_test.sv
// Purpose: Self-checking bench for the pod RAM run and target bus adapter
// Assumes: Inputs change on the falling clock edge
// Notes: Port pins are resolved here from the design's enables

module pod_ram_run_and_target_bus_adapter_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pod_adapter_pkg::*;
	logic i_clock, i_nrst, i_run_pod_program, i_ts_valid, i_ts_write, i_serial_in_line;
	logic i_host_valid, i_host_fetch, i_host_write, ext_on, fetch_on;
	logic [15:0] i_ts_addr;
	logic [7:0] i_ts_wdata, i_host_addr, i_host_wdata, p0_ext, p2_ext, rd;
	logic [2:0] i_host_port;
	logic o_ts_ready, o_ts_done, o_host_ready, o_host_done, o_host_reset_n, o_host_test_input;
	logic o_port1_oe, o_port3_high_oe, o_address_strobe_n, o_transfer_strobe_n;
	logic o_data_space_select_n, o_write_select_n, o_probe_sync;
	logic [7:0] o_rdata, o_port0, o_port0_oe, o_port1, o_port2, o_port2_oe, i_port0, i_port1, i_port2;
	logic [3:0] o_port3_high, i_port3_low, i_port3_high;
	int fails, cmp_count, cycles, probes, as_low, ds_low, busy;

	assign i_port0 = (o_port0 & o_port0_oe) | (p0_ext & ~o_port0_oe);
	assign i_port2 = (o_port2 & o_port2_oe) | (p2_ext & ~o_port2_oe);
	assign i_port3_low = {p2_ext[3:1], i_serial_in_line};
	assign i_port3_high = o_port3_high_oe ? o_port3_high : 4'h5;

	pod_ram_run_and_target_bus_adapter pod_ram_run_and_target_bus_adapter_i (
		.i_clock, .i_nrst, .i_run_pod_program, .i_ts_valid, .i_ts_write, .i_ts_addr,
		.i_ts_wdata, .o_ts_ready, .o_ts_done, .i_host_valid, .i_host_fetch, .i_host_write,
		.i_host_addr, .i_host_port, .i_host_wdata, .o_host_ready, .o_host_done,
		.o_host_reset_n, .o_host_test_input, .o_rdata, .i_port0, .o_port0, .o_port0_oe,
		.i_port1, .o_port1, .o_port1_oe, .i_port2, .o_port2, .o_port2_oe, .i_port3_low,
		.i_port3_high, .o_port3_high, .o_port3_high_oe, .i_serial_in_line,
		.o_address_strobe_n, .o_transfer_strobe_n, .o_data_space_select_n,
		.o_write_select_n, .o_probe_sync);

	target_board_model target_board_model_i (.i_clock(i_clock),
		.i_address_strobe_n(o_address_strobe_n), .i_transfer_strobe_n(o_transfer_strobe_n),
		.i_data_space_select_n(o_data_space_select_n), .i_write_select_n(o_write_select_n),
		.i_bus(o_port1), .i_bus_oe(o_port1_oe), .o_bus(i_port1));

	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	// ************************************************
	// Checking and bus tasks
	// ************************************************
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(negedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			test_done();
		end
		as_low += (o_address_strobe_n === 1'b0);
		ds_low += (o_transfer_strobe_n === 1'b0);
		busy += (o_ts_ready === 1'b0);
		probes += (o_probe_sync === 1'b1);
		if (o_transfer_strobe_n !== 1'b0 && (o_data_space_select_n !== 1'b1 || o_write_select_n !== 1'b1))
			chk("select_outside_strobe", 8'h0, 8'h1);
		if (fetch_on && (o_data_space_select_n !== 1'b1 || o_write_select_n !== 1'b1))
			chk("select_in_fetch", 8'h0, 8'h1);
		if (!ext_on && (o_address_strobe_n !== 1'b1 || o_transfer_strobe_n !== 1'b1))
			chk("strobe_when_idle", 8'h0, 8'h1);
	end

	task automatic ts_op(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clock);
		i_ts_valid = 1'b1;
		i_ts_write = w;
		i_ts_addr = a;
		i_ts_wdata = d;
		while (o_ts_ready !== 1'b1) @(negedge i_clock);
		@(negedge i_clock);
		i_ts_valid = 1'b0;
		while (o_ts_done !== 1'b1) @(negedge i_clock);
		rd = o_rdata;
	endtask

	task automatic host_op(input logic f, w, input logic [7:0] a, input logic [2:0] p,
		input logic [7:0] d);
		@(negedge i_clock);
		i_host_valid = 1'b1;
		i_host_fetch = f;
		i_host_write = w;
		i_host_addr = a;
		i_host_port = p;
		i_host_wdata = d;
		while (o_host_ready !== 1'b1) @(negedge i_clock);
		@(negedge i_clock);
		i_host_valid = 1'b0;
		while (o_host_done !== 1'b1) @(negedge i_clock);
		rd = o_rdata;
	endtask

	task automatic wait_hreset;
		int n;
		n = 0;
		while (o_host_reset_n !== 1'b0) @(negedge i_clock);
		while (o_host_reset_n === 1'b0) begin
			@(negedge i_clock);
			n++;
		end
		chk("host_reset_len", 8'(HOST_RESET_CYCLES), 8'(n));
	endtask

	// ************************************************
	// Scenarios
	// ************************************************
	task automatic t_ram;
		ts_op(1'b1, 16'h3000, 8'h11);
		ts_op(1'b1, 16'h30ff, 8'hee);
		ts_op(1'b1, 16'h3005, 8'h6c);
		ts_op(1'b0, 16'h3000, 8'h00);
		chk("ram_low", 8'h11, rd);
		ts_op(1'b0, 16'h30ff, 8'h00);
		chk("ram_high", 8'hee, rd);
	endtask

	task automatic t_ports;
		ts_op(1'b1, ADDR_P0L, 8'h05);
		ts_op(1'b1, ADDR_P0H, 8'h0a);
		chk("port0_out", 8'ha5, o_port0);
		chk("port0_oe", 8'hff, o_port0_oe);
		p0_ext = 8'h3c;
		ts_op(1'b0, ADDR_P0L, 8'h00);
		repeat (3) @(negedge i_clock);
		ts_op(1'b0, ADDR_P0L, 8'h00);
		chk("port0_low_in", 8'h0c, rd);
		chk("port0_oe_in", 8'hf0, o_port0_oe);
		ts_op(1'b1, ADDR_P3H, 8'h0a);
		chk("port3_high", 8'h8a, {o_port3_high_oe, 3'h0, o_port3_high});
		ts_op(1'b0, ADDR_P3L, 8'h00);
		chk("port3_low_in", 8'h0e, rd);
		ts_op(1'b1, ADDR_MODE, 8'h10);
		ts_op(1'b0, ADDR_P0H, 8'h00);
		chk("port0_readback", 8'h0a, rd);
		chk("port0_oe_kept", 8'hf0, o_port0_oe);
	endtask

	task automatic t_ext;
		ts_op(1'b1, ADDR_MODE, 8'h01);
		ts_op(1'b1, ADDR_P1, 8'h77);
		chk("port1_static", 8'h77, o_port1);
		ext_on = 1'b1;
		{as_low, ds_low, busy, probes} = '0;
		ts_op(1'b1, 16'h11ca, 8'h3b);
		chk("as_low_cycles", 8'(AS_END - AS_START), 8'(as_low));
		chk("ds_low_cycles", 8'(DS_END - DS_START), 8'(ds_low));
		chk("ext_cycle_len", 8'(EXT_CYCLES), 8'(busy));
		chk("probe_pulses", 8'h2, 8'(probes));
		chk("board_write", 8'h3b, target_board_model_i.mem[8'hca]);
		chk("port1_released", 8'h0, {7'h0, o_port1_oe});
		ts_op(1'b0, 16'h11ca, 8'h00);
		chk("ext_read", 8'h3b, rd);
		fetch_on = 1'b1;
		ts_op(1'b0, 16'h0457, 8'h00);
		fetch_on = 1'b0;
		chk("prog_fetch", 8'h57 ^ 8'h5a, rd);
		ext_on = 1'b0;
	endtask

	task automatic t_run;
		ts_op(1'b1, ADDR_P0L, 8'h06);
		@(negedge i_clock);
		i_run_pod_program = 1'b1;
		wait_hreset();
		chk("oe_after_start", 8'h0, o_port0_oe);
		chk("port2_after_start", 8'hff, o_port2);
		host_op(1'b1, 1'b0, 8'h05, 3'h0, 8'h00);
		chk("pod_fetch", 8'h6c, rd);
		host_op(1'b0, 1'b1, 8'h00, HPORT_P2, 8'h01);
		host_op(1'b0, 1'b1, 8'h00, HPORT_P1, 8'h0f);
		chk("host_p1", 8'h0f, o_port2);
		chk("host_p1_oe", 8'hf0, o_port2_oe);
		host_op(1'b0, 1'b1, 8'h00, HPORT_X5, 8'h09);
		chk("host_x5", 8'h09, {4'h0, o_port0[7:4]});
		chk("host_x5_oe", 8'hf0, o_port0_oe);
		host_op(1'b0, 1'b0, 8'h00, HPORT_X4, 8'h00);
		chk("host_x4", 8'h0c, rd);
		i_serial_in_line = 1'b1;
		repeat (4) @(negedge i_clock);
		chk("test_input_hi", 8'h1, {7'h0, o_host_test_input});
		i_serial_in_line = 1'b0;
		repeat (4) @(negedge i_clock);
		chk("test_input_lo", 8'h0, {7'h0, o_host_test_input});
		i_run_pod_program = 1'b0;
		wait_hreset();
		ts_op(1'b0, ADDR_MODE, 8'h00);
		chk("mode_after_end", MODE_RESET, rd);
	endtask

	initial begin
		{i_run_pod_program, i_ts_valid, i_ts_write, i_serial_in_line} = '0;
		{i_host_valid, i_host_fetch, i_host_write, ext_on, fetch_on} = '0;
		{i_ts_addr, i_ts_wdata, i_host_addr, i_host_wdata, i_host_port} = '0;
		{fails, cmp_count, cycles, probes, as_low, ds_low, busy} = '0;
		p0_ext = 8'h00;
		p2_ext = 8'hff;
		i_nrst = 1'b0;
		repeat (3) @(negedge i_clock);
		i_nrst = 1'b1;
		t_ram();
		t_ports();
		t_ext();
		t_run();
		test_done();
	end
endmodule

// File: testbench/target_board_model.sv
// Purpose: Target board memory seen over the multiplexed port 1 bus
// Assumes: Address is on the bus while the address strobe is low
// Notes: Program space answers address xor 5a; data space is a 256-byte store

module target_board_model (
	input wire logic i_clock,
	input wire logic i_address_strobe_n,
	input wire logic i_transfer_strobe_n,
	input wire logic i_data_space_select_n,
	input wire logic i_write_select_n,
	input wire logic [7:0] i_bus,
	input wire logic i_bus_oe,
	output logic [7:0] o_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	logic [7:0] addr_ff;
	logic [7:0] rd;

	always_ff @(posedge i_clock) begin
		if (!i_address_strobe_n)
			addr_ff <= i_bus;
		if (!i_transfer_strobe_n && !i_write_select_n && !i_data_space_select_n)
			mem[addr_ff] <= i_bus;
	end

	assign rd = i_data_space_select_n ? (addr_ff ^ 8'h5a) : mem[addr_ff];
	// Released bus shows inverted data outside read strobes so a stale value never matches
	assign o_bus = i_bus_oe ? i_bus : ((!i_transfer_strobe_n && i_write_select_n) ? rd : ~rd);
endmodule
